// ==== ccdf_defines.svh ====
// constants for the channel clock divider and fanout block
`ifndef CCDF_DEFINES_SVH
`define CCDF_DEFINES_SVH
// Functional notes
// [RL1] four channels, each divider selectable among 1,2,3,4,6,8,12,16,24
// [RL2] 4-bit divider code: 0000 bypass ratio 1, 0001..1000 ratios 2..24
// [RL3] all dividers run from the input clock with equal latency for any ratio
// [RL4] channels A and D divide by 1 after power-up
// [RL5] channels B and C default to ratio 3 if strap low, ratio 4 if high
// [RL6] an unconnected divider default strap reads as high
// [RL7] clock outputs with equal phase delay switch on the same input edge
// [RL8] sysref outputs with equal delay settings are mutually synchronous
// [RL9] clock and sysref outputs keep a fixed timing relation
// [RL10] eight divided clock outputs, sysref replicated with per-output delay
// [RL11] sysref path does not depend on divider settings
// [RL12] every channel and unused output can be powered down by configuration; a divided clock output only together with its whole channel
// [RL13] configuration registers are written and read back over spi
// [RL14] spi data line is bidirectional, device drives it only for read data
// [RL15] undriven chip select is deasserted, undriven serial clock is low
// [RL16] clock phase delay counts whole input periods, 256 steps
// [RL17] divider codes 1001 to 1111 are reserved
`define CCDF_ADDR_DIV 7'h00
`define CCDF_ADDR_PHASE 7'h04
`define CCDF_ADDR_SREF 7'h08
`define CCDF_ADDR_STATUS 7'h10
`define CCDF_DIV_BYPASS 4'h0
`define CCDF_DIV_RATIO3 4'h2
`define CCDF_DIV_RATIO4 4'h3
`define CCDF_DIV_MAX 4'h8
`define CCDF_PHASE_WRAP 6'h30
`define CCDF_PHASE_LAST 6'h2F
`define CCDF_SPI_HDR_LAST 5'h07
`define CCDF_SPI_FRAME 5'h10
`define CCDF_INIT_WAIT 2'h2
`endif

// ==== ccdf_pkg.sv ====
// types for the channel clock divider and fanout block
package ccdf_pkg;
  typedef enum logic [3:0] {
    CCDF_IDLE = 4'h1,
    CCDF_HDR = 4'h2,
    CCDF_WDATA = 4'h4,
    CCDF_RDATA = 4'h8
  } ccdf_spi_state_type;
endpackage

// ==== ccdf_top.sv ====
// four-channel clock divider, sysref fanout and spi register port
`timescale 1ns/1ps
`include "ccdf_defines.svh"
module ccdf_top import ccdf_pkg::*; #(
  parameter int NUM_SREF = 8,
  parameter int SREF_STEPS = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sysref_in,
  input wire logic bc_divider_default_strap,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_bidir_data_in,
  output logic spi_bidir_data_out,
  output logic spi_bidir_data_oe,
  output logic [7:0] divided_clock_output,
  output logic [NUM_SREF-1:0] sysref_fanout_output
);
  // elaboration check on the sysref fanout shape
  if (NUM_SREF < 1 || NUM_SREF > 8 || SREF_STEPS != 8) begin : g_bad_param
    $error("ccdf_top: sysref needs 1..8 outputs and 8 delay steps");
  end

  // channel that feeds each clock output: A has 3, B 2, C 2, D 1
  function automatic logic [1:0] ch_of(input int y);
    ch_of = (y < 3) ? 2'd0 : (y < 5) ? 2'd1 : (y < 7) ? 2'd2 : 2'd3;
  endfunction

  // true when the aligned phase count lands on an edge of the ratio
  function automatic logic on_edge(input logic [5:0] d, input logic [3:0] code);
    case (code)
      4'h0: on_edge = 1'b1;
      4'h1: on_edge = (d % 6'd2) == 6'd0;
      4'h2: on_edge = (d % 6'd3) == 6'd0;
      4'h3: on_edge = (d % 6'd4) == 6'd0;
      4'h4: on_edge = (d % 6'd6) == 6'd0;
      4'h5: on_edge = (d % 6'd8) == 6'd0;
      4'h6: on_edge = (d % 6'd12) == 6'd0;
      4'h7: on_edge = (d % 6'd16) == 6'd0;
      4'h8: on_edge = (d % 6'd24) == 6'd0;
      default: on_edge = 1'b0;
    endcase
  endfunction

  // pin synchronisers; idle levels at reset: strap high, cs high, sclk low
  logic strap_s1_reg, strap_s2_reg, sref_s1_reg, sref_s2_reg;
  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic cs_s1_reg, cs_s2_reg, mosi_s1_reg, mosi_s2_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_s1_reg <= 1'b1; // RL6
      strap_s2_reg <= 1'b1;
      sref_s1_reg <= 1'b0;
      sref_s2_reg <= 1'b0;
      sclk_s1_reg <= 1'b0; // RL15
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_s1_reg <= 1'b1; // RL15
      cs_s2_reg <= 1'b1;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
    end else begin
      strap_s1_reg <= bc_divider_default_strap;
      strap_s2_reg <= strap_s1_reg;
      sref_s1_reg <= sysref_in;
      sref_s2_reg <= sref_s1_reg;
      sclk_s1_reg <= spi_sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg <= spi_cs_n;
      cs_s2_reg <= cs_s1_reg;
      mosi_s1_reg <= spi_bidir_data_in;
      mosi_s2_reg <= mosi_s1_reg;
    end
  end

  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  assign sclk_fall = ~sclk_s2_reg & sclk_s3_reg;

  // configuration state
  logic [3:0][3:0] div_reg, div_next;
  logic [3:0] ch_pd_reg, ch_pd_next;
  logic [3:0][7:0] phase_reg, phase_next;
  logic [NUM_SREF-1:0][2:0] sref_dly_reg, sref_dly_next;
  logic [NUM_SREF-1:0] sref_en_reg, sref_en_next;
  logic strap_reg, strap_next, init_done_reg, init_done_next;
  logic [1:0] init_cnt_reg, init_cnt_next;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;

  // register read mux for spi read-back
  function automatic logic [7:0] reg_read(input logic [6:0] a);
    reg_read = 8'h00;
    if (a < `CCDF_ADDR_PHASE) begin
      reg_read = {ch_pd_reg[a[1:0]], 3'h0, div_reg[a[1:0]]};
    end else if (a < `CCDF_ADDR_SREF) begin
      reg_read = phase_reg[a[1:0]];
    end else if (a < `CCDF_ADDR_STATUS) begin
      if (32'(a[2:0]) < NUM_SREF) begin
        reg_read = {sref_en_reg[a[2:0]], 4'h0, sref_dly_reg[a[2:0]]};
      end
    end else if (a == `CCDF_ADDR_STATUS) begin
      reg_read = {6'h00, init_done_reg, strap_reg};
    end
  endfunction

  // configuration next state: strap load once after reset, then spi writes
  always_comb begin
    div_next = div_reg;
    ch_pd_next = ch_pd_reg;
    phase_next = phase_reg;
    sref_dly_next = sref_dly_reg;
    sref_en_next = sref_en_reg;
    strap_next = strap_reg;
    init_done_next = init_done_reg;
    init_cnt_next = init_cnt_reg;
    // wait until the strap synchroniser holds the pin, not its reset value
    if (!init_done_reg) begin
      if (init_cnt_reg == `CCDF_INIT_WAIT) begin
        init_done_next = 1'b1;
        strap_next = strap_s2_reg;
        div_next[1] = strap_s2_reg ? `CCDF_DIV_RATIO4 : `CCDF_DIV_RATIO3; // RL5
        div_next[2] = strap_s2_reg ? `CCDF_DIV_RATIO4 : `CCDF_DIV_RATIO3; // RL5
      end else begin
        init_cnt_next = init_cnt_reg + 2'h1;
      end
    end else if (wr_en) begin
      if (wr_addr < `CCDF_ADDR_PHASE) begin
        div_next[wr_addr[1:0]] = wr_data[3:0]; // RL13
        ch_pd_next[wr_addr[1:0]] = wr_data[7]; // RL12
      end else if (wr_addr < `CCDF_ADDR_SREF) begin
        phase_next[wr_addr[1:0]] = wr_data; // RL16
      end else if (wr_addr < `CCDF_ADDR_STATUS && 32'(wr_addr[2:0]) < NUM_SREF) begin
        sref_dly_next[wr_addr[2:0]] = wr_data[2:0];
        sref_en_next[wr_addr[2:0]] = wr_data[7]; // RL12
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_reg <= {`CCDF_DIV_BYPASS, `CCDF_DIV_RATIO4, `CCDF_DIV_RATIO4,
                  `CCDF_DIV_BYPASS}; // RL4
      ch_pd_reg <= 4'h0;
      phase_reg <= '0;
      sref_dly_reg <= '0;
      sref_en_reg <= '0;
      strap_reg <= 1'b1;
      init_done_reg <= 1'b0;
      init_cnt_reg <= 2'h0;
    end else begin
      div_reg <= div_next;
      ch_pd_reg <= ch_pd_next;
      phase_reg <= phase_next;
      sref_dly_reg <= sref_dly_next;
      sref_en_reg <= sref_en_next;
      strap_reg <= strap_next;
      init_done_reg <= init_done_next;
      init_cnt_reg <= init_cnt_next;
    end
  end

  // common phase base over the lcm of all ratios, shared by every channel
  logic [5:0] base_reg, base_next;
  logic [3:0] tick;
  logic [7:0] clk_out_next;
  always_comb begin
    base_next = (base_reg == `CCDF_PHASE_LAST) ? 6'h00 : base_reg + 6'h01;
  end

  for (genvar c = 0; c < 4; c++) begin : g_ch
    logic [5:0] pm, d;
    assign pm = 6'(phase_reg[c] % 8'd48); // RL16
    assign d = (base_reg >= pm) ? base_reg - pm : 6'(base_reg + `CCDF_PHASE_WRAP - pm);
    // reserved codes and powered-down channels stay low
    assign tick[c] = !ch_pd_reg[c] && on_edge(d, div_reg[c]); // RL1 RL2 RL7 RL12 RL17
  end

  // one register stage for every ratio keeps latency equal
  for (genvar y = 0; y < 8; y++) begin : g_out
    assign clk_out_next[y] = tick[ch_of(y)]; // RL3 RL10
  end

  // sysref delay line, fed only by the sysref pin
  logic [7:0] line_reg, line_next;
  logic [NUM_SREF-1:0] sref_out_next;
  always_comb begin
    line_next = {line_reg[6:0], sref_s2_reg}; // RL11
    for (int r = 0; r < NUM_SREF; r++) begin
      sref_out_next[r] = sref_en_reg[r] && line_reg[sref_dly_reg[r]]; // RL8 RL10
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      base_reg <= 6'h00;
      divided_clock_output <= 8'h00;
      line_reg <= 8'h00;
      sysref_fanout_output <= '0;
    end else begin
      base_reg <= base_next;
      divided_clock_output <= clk_out_next; // RL9
      line_reg <= line_next;
      sysref_fanout_output <= sref_out_next; // RL9
    end
  end

  // spi frame: rw bit, 7-bit address, 8 data bits, msb first on rising sclk
  ccdf_spi_state_type state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [15:0] shift_reg, shift_next;
  logic [7:0] rd_reg, rd_next;
  logic sdo_reg, sdo_next, oe_reg, oe_next;
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    rd_next = rd_reg;
    sdo_next = sdo_reg;
    oe_next = oe_reg;
    wr_en = 1'b0;
    wr_addr = shift_reg[13:7];
    wr_data = {shift_reg[6:0], mosi_s2_reg};
    if (cs_s2_reg) begin
      state_next = CCDF_IDLE; // RL15
      cnt_next = 5'h00;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        CCDF_IDLE: begin
          state_next = CCDF_HDR;
          cnt_next = 5'h00;
        end
        CCDF_HDR: begin
          if (sclk_rise) begin
            shift_next = {shift_reg[14:0], mosi_s2_reg};
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == `CCDF_SPI_HDR_LAST) begin
              state_next = shift_reg[6] ? CCDF_RDATA : CCDF_WDATA;
              rd_next = reg_read({shift_reg[5:0], mosi_s2_reg}); // RL13
            end
          end
        end
        CCDF_WDATA: begin
          if (sclk_rise && cnt_reg < `CCDF_SPI_FRAME) begin
            shift_next = {shift_reg[14:0], mosi_s2_reg};
            cnt_next = cnt_reg + 5'h01;
            wr_en = (cnt_reg == `CCDF_SPI_FRAME - 5'h01); // RL13
          end
        end
        CCDF_RDATA: begin
          if (sclk_fall && cnt_reg < `CCDF_SPI_FRAME) begin
            sdo_next = rd_reg[7];
            rd_next = {rd_reg[6:0], 1'b0};
            oe_next = 1'b1; // RL14
          end
          if (sclk_rise && cnt_reg < `CCDF_SPI_FRAME) begin
            cnt_next = cnt_reg + 5'h01;
          end
        end
        default: state_next = CCDF_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= CCDF_IDLE;
      cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      rd_reg <= 8'h00;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      rd_reg <= rd_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
    end
  end

  assign spi_bidir_data_out = sdo_reg;
  assign spi_bidir_data_oe = oe_reg; // RL14

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_cfg3;
    div_reg[2] == `CCDF_DIV_RATIO3 && !ch_pd_reg[2] && $stable(phase_reg[2]);
  endsequence
  sequence s_cfg_by1;
    div_reg[0] == `CCDF_DIV_BYPASS && !ch_pd_reg[0];
  endsequence

  chk_div3_period: assert property ( // RL1
    s_cfg3 ##1 (s_cfg3 and divided_clock_output[5]) ##1 s_cfg3[*2] |=>
      divided_clock_output[5] && !$past(divided_clock_output[5])
      && !$past(divided_clock_output[5], 2))
    else $error("ratio 3 output period wrong");
  chk_bypass_every: assert property (s_cfg_by1 |=> divided_clock_output[2:0] == 3'h7) // RL2
    else $error("bypass channel not high every cycle");
  chk_reserved_low: assert property ( // RL17
    div_reg[3] > `CCDF_DIV_MAX |=> !divided_clock_output[7])
    else $error("reserved code produced edges");
  chk_pd_low: assert property (ch_pd_reg[2] |=> divided_clock_output[6:5] == 2'h0) // RL12
    else $error("powered-down channel toggles");
  chk_phase_align: assert property ( // RL7
    (!ch_pd_reg[1] && !ch_pd_reg[2] && phase_reg[1] == phase_reg[2]
     && div_reg[1] <= `CCDF_DIV_MAX && div_reg[2] <= `CCDF_DIV_MAX
     && base_reg == 6'(phase_reg[1] % 8'd48))
    |=> divided_clock_output[3] && divided_clock_output[5])
    else $error("equal phase channels not aligned");
  chk_strap_load: assert property ( // RL5
    $rose(init_done_reg) |-> div_reg[1] == (strap_reg ? `CCDF_DIV_RATIO4 : `CCDF_DIV_RATIO3)
      && div_reg[0] == `CCDF_DIV_BYPASS && div_reg[3] == `CCDF_DIV_BYPASS)
    else $error("divider defaults wrong after reset");
  chk_sref_delay: assert property ( // RL8
    (sref_en_reg[0] && sref_dly_reg[0] == 3'h2)[*2] |->
      sysref_fanout_output[0] == $past(sref_s2_reg, 4))
    else $error("sysref delay two path latency wrong");
  chk_sref_off: assert property (!sref_en_reg[1] |=> !sysref_fanout_output[1]) // RL12
    else $error("disabled sysref output active");
  chk_oe_read_only: assert property (spi_bidir_data_oe |-> state_reg == CCDF_RDATA) // RL14
    else $error("data line driven outside read");
  chk_cs_abort: assert property (cs_s2_reg |=> state_reg == CCDF_IDLE && !spi_bidir_data_oe) // RL15
    else $error("spi not idle after chip select release");
endmodule

// ==== ccdf_spi_host.sv ====
// spi host model for the three-wire configuration port
`timescale 1ns/1ps
module ccdf_spi_host (
  input wire logic clk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic host_data,
  output logic host_en,
  input wire logic data_wire
);
  // idle: deselected, serial clock low, line released
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    host_data = 1'b0;
    host_en = 1'b0;
  end
  // wait on falling clock edges so pins never move on the sampling edge
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one frame, msb first: read flag, address, data; q holds read bits
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
      output logic [7:0] q);
    logic [15:0] w;
    w = {rd, a, d};
    q = 8'h00;
    gap(1);
    spi_cs_n = 1'b0;
    host_en = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      gap(6);
      spi_sclk = 1'b0;
      if (rd && i < 8) begin
        host_en = 1'b0;
        host_data = ~host_data; // released line shows no stale level
      end else begin
        host_data = w[i];
      end
      gap(6);
      q = {q[6:0], data_wire};
      spi_sclk = 1'b1;
    end
    gap(6);
    spi_cs_n = 1'b1;
    host_en = 1'b0;
    gap(6);
    spi_sclk = 1'b0;
    gap(8);
  endtask
endmodule

// ==== tb.sv ====
// self-checking bench for the clock divider and sysref fanout block
`timescale 1ns/1ps
module tb;
  import ccdf_pkg::*;
  typedef struct {logic [3:0] code; int n;} ccdf_row_type;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sysref_in = 1'b0;
  logic strap = 1'b1;
  logic spi_sclk, spi_cs_n, host_data, host_en, data_out, data_oe, data_wire;
  logic [7:0] dco;
  logic [7:0] sref;
  int fail_count = 0;
  int compares = 0;
  int clash = 0;
  ccdf_row_type rows [9] = '{'{4'h0, 48}, '{4'h1, 24}, '{4'h2, 16}, '{4'h3, 12},
    '{4'h4, 8}, '{4'h5, 6}, '{4'h6, 4}, '{4'h7, 3}, '{4'h8, 2}};
  // 50 MHz clock
  always #10 clk = ~clk;
  // data pin level from whoever drives it
  assign data_wire = (data_oe === 1'b1) ? data_out : host_data;
  ccdf_top ccdf_top_i (.clk(clk), .reset(reset), .sysref_in(sysref_in),
    .bc_divider_default_strap(strap), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_bidir_data_in(data_wire), .spi_bidir_data_out(data_out),
    .spi_bidir_data_oe(data_oe), .divided_clock_output(dco),
    .sysref_fanout_output(sref));
  ccdf_spi_host ccdf_spi_host_i (.clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .host_data(host_data), .host_en(host_en), .data_wire(data_wire));
  // both ends driving the data pin at once
  always @(posedge clk) if (data_oe === 1'b1 && host_en === 1'b1) clash++;
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // counts, report, verdict
  task automatic test_done;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    ccdf_spi_host_i.xfer(1'b0, a, d, q);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    ccdf_spi_host_i.xfer(1'b1, a, 8'h00, q);
    chk("readback", e, q);
  endtask
  task automatic do_reset(input logic s);
    @(negedge clk);
    reset = 1'b1;
    strap = s;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // pulses per output over one 48-cycle period, a multiple of every ratio
  task automatic count48(output int n [8]);
    n = '{default: 0};
    repeat (48) begin
      @(negedge clk);
      for (int b = 0; b < 8; b++) n[b] += (dco[b] === 1'b1);
    end
  endtask
  task automatic chk_defaults(input int nbc, input logic [7:0] st);
    int n [8];
    count48(n);
    chk("ch_a", 48, n[0]);
    chk("ch_b", nbc, n[3]);
    chk("ch_c", nbc, n[6]);
    chk("ch_d", 48, n[7]);
    rdchk(7'h10, st);
  endtask
  // one sysref pulse; k, j: cycles until outputs 0 and 2 rise
  task automatic pulse(output int k, output int j, output int bad);
    k = 0;
    j = 0;
    bad = 0;
    @(negedge clk);
    sysref_in = 1'b1;
    for (int i = 0; i < 24; i++) begin
      @(negedge clk);
      if (sref[0] !== sref[1] || sref[7:3] !== 5'h00) bad++;
      if (sref[0] !== 1'b1) k++;
      if (sref[2] !== 1'b1) j++;
    end
    sysref_in = 1'b0;
    repeat (24) @(negedge clk);
  endtask
  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    test_done();
  end
  initial begin
    int n [8];
    int bad, k1, j1, k2, j2;
    logic prev;
    do_reset(1'b1);
    chk_defaults(12, 8'h03);
    foreach (rows[i]) begin
      wr(7'h01, {4'h0, rows[i].code});
      count48(n);
      chk("div_b", rows[i].n, n[4]);
      rdchk(7'h01, {4'h0, rows[i].code});
    end
    rdchk(7'h20, 8'h00);
    // ratios 2, 3 and 6 must coincide on every ratio-6 edge
    wr(7'h00, 8'h01);
    wr(7'h02, 8'h02);
    wr(7'h03, 8'h04);
    bad = 0;
    k1 = 0;
    repeat (48) begin
      @(negedge clk);
      if (dco[7] === 1'b1) k1++;
      if (dco[7] === 1'b1 && !(dco[0] === 1'b1 && dco[5] === 1'b1)) bad++;
    end
    chk("sync", 0, bad);
    chk("sync_d", 8, k1);
    // channel D one input period behind channel A
    wr(7'h00, 8'h04);
    wr(7'h07, 8'h01);
    bad = 0;
    @(negedge clk);
    prev = dco[0];
    repeat (48) begin
      @(negedge clk);
      if (dco[7] !== prev) bad++;
      prev = dco[0];
    end
    chk("phase", 0, bad);
    wr(7'h02, 8'h80);
    count48(n);
    chk("pd_c", 0, n[5] + n[6]);
    rdchk(7'h02, 8'h80);
    wr(7'h03, 8'h09);
    count48(n);
    chk("rsvd_d", 0, n[7]);
    // sysref copies: 0 and 1 at delay 2, 2 at delay 5, rest disabled
    wr(7'h08, 8'h82);
    wr(7'h09, 8'h82);
    wr(7'h0A, 8'h85);
    pulse(k1, j1, bad);
    chk("sref_sync", 0, bad);
    chk("sref_seen", 1, k1 < 24);
    chk("sref_dly", 3, j1 - k1);
    wr(7'h01, 8'h00);
    wr(7'h03, 8'h88);
    pulse(k2, j2, bad);
    chk("sref_lat", k1, k2);
    chk("sref_lat2", j1, j2);
    chk("clash", 0, clash);
    do_reset(1'b0);
    chk_defaults(16, 8'h02);
    test_done();
  end
endmodule
